// *** core/gepc_regs.sv ***
// Register slice: general purpose pin control, EEPROM access control and the
// express capability header and device capabilities words.
// Assumes a classic Wishbone master on clk_i, an EEPROM engine on the same
// clock that answers each request with a one-cycle done pulse, and pins that
// arrive asynchronously.
`timescale 1ns/1ns
`default_nettype none

// Contract
// - Pin word bits 7:0 return live synchronised level of each pin.
// - Pin word bit x+8 sets direction: zero input, one output.
// - Pin word bit x+16 is the driven level, used only when output.
// - Setting EEPROM start launches one cycle with command and word address.
// - Command 01b writes, 10b reads, 00b and 11b reserved; resets 00b.
// - EEPROM bits 31:16 hold write data, read/write, reset zero.
// - Capability identifier byte always reads 10h.
// - Next capability pointer reads 00h, ending the list.
// - Capability version reads 0001b.
// - Device/port type bits 23:20 read 1h, legacy endpoint.
// - Slot implemented reads zero; interrupt message number reads 00000b.
// - Maximum payload supported bits 2:0 read 000b, 128 bytes.
// - L0s and L1 acceptable latency fields read 000b after reset.
// - Role-based error bit resets to one; EEPROM auto-load may replace it.
// - Slot power value and scale load from the power limit message.
// - Phantom, extended tag, attention and power indicator bits read zero.
module gepc_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] pin_in_i,
  output logic [7:0] pin_out_o,
  output logic [7:0] pin_oe_o,
  output logic ee_req_o,
  output logic [1:0] ee_cmd_o,
  output logic [10:0] ee_addr_o,
  output logic [15:0] ee_wdata_o,
  output logic ee_preload_o,
  input wire logic ee_done_i,
  input wire logic [15:0] ee_rdata_i,
  input wire logic rbe_load_i,
  input wire logic rbe_value_i,
  input wire logic spl_msg_i,
  input wire logic [7:0] spl_value_i,
  input wire logic [1:0] spl_scale_i
);

  // ---------------------------------------------------------------------
  // State.
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] sync1;
    logic [7:0] sync2;
    gepc_pkg::gepc_pin_s pin;
    gepc_pkg::gepc_eereq_s ee;
    logic ee_rej;
    logic [15:0] ee_rdata;
    logic rbe;
    logic [7:0] spv;
    logic [1:0] sps;
    logic ack;
    logic [31:0] rdat;
  } gepc_state_s;

  gepc_state_s st_ff;
  gepc_state_s nxt_st;

  logic wb_req;
  logic wb_commit;
  logic launch;
  logic [31:0] pin_word;
  logic [31:0] eep_word;
  logic [31:0] cap_word;
  logic [31:0] dev_word;
  logic [31:0] est_word;
  logic [31:0] rd_word;

  // Merge write data into an old word under the byte enables.
  function automatic logic [31:0] gepc_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction : gepc_merge

  // ---------------------------------------------------------------------
  // Bus handshake.
  // ---------------------------------------------------------------------

  // A request is answered one cycle after it is seen; the write commits on
  // the edge at which the master samples the acknowledge, so a master that
  // aborts before then changes nothing.
  assign wb_req = wb_cyc_i & wb_stb_i;
  assign wb_commit = wb_req & wb_we_i & st_ff.ack;

  // ---------------------------------------------------------------------
  // Register views.
  // ---------------------------------------------------------------------

  // Pin word; the top byte is reserved and stays zero.
  always_comb begin
    pin_word = gepc_pkg::GEPC_WORD_ZERO;
    pin_word[gepc_pkg::GEPC_PIN_IN_LSB +: 8] = st_ff.sync2;
    pin_word[gepc_pkg::GEPC_PIN_DIR_LSB +: 8] = st_ff.pin.dir;
    pin_word[gepc_pkg::GEPC_PIN_OUT_LSB +: 8] = st_ff.pin.out;
  end

  // EEPROM word; the start bit reads back as one while a cycle is running.
  always_comb begin
    eep_word = gepc_pkg::GEPC_WORD_ZERO;
    eep_word[gepc_pkg::GEPC_EE_START_BIT] = st_ff.ee.req;
    eep_word[gepc_pkg::GEPC_EE_PRE_BIT] = st_ff.ee.preload;
    eep_word[gepc_pkg::GEPC_EE_CMD_LSB +: 2] = st_ff.ee.cmd;
    eep_word[gepc_pkg::GEPC_EE_ADR_LSB +: 11] = st_ff.ee.addr;
    eep_word[gepc_pkg::GEPC_EE_WD_LSB +: 16] = st_ff.ee.wdata;
  end

  // Capability header is all constant; bits 31:30 stay zero.
  always_comb begin
    cap_word = gepc_pkg::GEPC_WORD_ZERO;
    cap_word[gepc_pkg::GEPC_CAP_ID_LSB +: 8] = gepc_pkg::GEPC_CAP_ID;
    cap_word[gepc_pkg::GEPC_CAP_NXT_LSB +: 8] =
      gepc_pkg::GEPC_CAP_NEXT;
    cap_word[gepc_pkg::GEPC_CAP_VER_LSB +: 4] =
      gepc_pkg::GEPC_CAP_VER;
    cap_word[gepc_pkg::GEPC_CAP_TYPE_LSB +: 4] =
      gepc_pkg::GEPC_CAP_TYPE;
    cap_word[gepc_pkg::GEPC_CAP_SLOT_BIT] = gepc_pkg::GEPC_CAP_SLOT;
    cap_word[gepc_pkg::GEPC_CAP_MSG_LSB +: 5] =
      gepc_pkg::GEPC_CAP_MSG;
  end

  // Device capabilities; only the role-based error bit and the captured
  // slot power fields carry state.
  always_comb begin
    dev_word = gepc_pkg::GEPC_WORD_ZERO;
    dev_word[gepc_pkg::GEPC_DEV_MPS_LSB +: 3] =
      gepc_pkg::GEPC_DEV_MPS;
    dev_word[gepc_pkg::GEPC_DEV_PH_LSB +: 2] =
      gepc_pkg::GEPC_DEV_PHANTOM;
    dev_word[gepc_pkg::GEPC_DEV_ETAG_BIT] =
      gepc_pkg::GEPC_DEV_UNIMPL;
    dev_word[gepc_pkg::GEPC_DEV_L0S_LSB +: 3] =
      gepc_pkg::GEPC_DEV_LAT_RST;
    dev_word[gepc_pkg::GEPC_DEV_L1_LSB +: 3] =
      gepc_pkg::GEPC_DEV_LAT_RST;
    dev_word[gepc_pkg::GEPC_DEV_ABP_BIT] =
      gepc_pkg::GEPC_DEV_UNIMPL;
    dev_word[gepc_pkg::GEPC_DEV_AIP_BIT] =
      gepc_pkg::GEPC_DEV_UNIMPL;
    dev_word[gepc_pkg::GEPC_DEV_PIP_BIT] =
      gepc_pkg::GEPC_DEV_UNIMPL;
    dev_word[gepc_pkg::GEPC_DEV_RBE_BIT] = st_ff.rbe;
    dev_word[gepc_pkg::GEPC_DEV_SPV_LSB +: 8] = st_ff.spv;
    dev_word[gepc_pkg::GEPC_DEV_SPS_LSB +: 2] = st_ff.sps;
  end

  // EEPROM status word: busy, rejected-command flag and last read word.
  always_comb begin
    est_word = gepc_pkg::GEPC_WORD_ZERO;
    est_word[gepc_pkg::GEPC_EST_BUSY_BIT] = st_ff.ee.req;
    est_word[gepc_pkg::GEPC_EST_REJ_BIT] = st_ff.ee_rej;
    est_word[gepc_pkg::GEPC_EST_RD_LSB +: 16] = st_ff.ee_rdata;
  end

  // Read multiplexer; an unmapped address reads as zero.
  always_comb begin
    unique case (wb_adr_i)
      gepc_pkg::GEPC_OFF_PIN: rd_word = pin_word;
      gepc_pkg::GEPC_OFF_EEP: rd_word = eep_word;
      gepc_pkg::GEPC_OFF_CAP: rd_word = cap_word;
      gepc_pkg::GEPC_OFF_DEV: rd_word = dev_word;
      gepc_pkg::GEPC_OFF_EST: rd_word = est_word;
      default: rd_word = gepc_pkg::GEPC_WORD_ZERO;
    endcase
  end

  // ---------------------------------------------------------------------
  // Next-state logic.
  // ---------------------------------------------------------------------

  // A launch needs a committed write that sets the start bit while idle and
  // carries a defined command; a start with a reserved command is refused
  // and only flags it, since the engine has nothing to run. Software is
  // expected to wait out a running cycle, so a start while busy is dropped.
  always_comb begin
    logic [31:0] eep_new;
    logic [31:0] pin_new;
    logic [1:0] cmd_new;
    logic start_new;
    eep_new = gepc_merge(eep_word, wb_dat_i, wb_sel_i);
    pin_new = gepc_merge(pin_word, wb_dat_i, wb_sel_i);
    cmd_new = eep_new[gepc_pkg::GEPC_EE_CMD_LSB +: 2];
    start_new = eep_new[gepc_pkg::GEPC_EE_START_BIT];
    launch = 1'b0;
    nxt_st = st_ff;

    // Two-flop synchroniser for the pin levels.
    nxt_st.sync1 = pin_in_i;
    nxt_st.sync2 = st_ff.sync1;

    // Acknowledge rises one cycle after the request and drops after one.
    nxt_st.ack = wb_req & ~st_ff.ack;
    if (wb_req & ~st_ff.ack) begin
      nxt_st.rdat = rd_word;
    end

    // Pin control writes; input and reserved bytes are ignored.
    if (wb_commit && wb_adr_i == gepc_pkg::GEPC_OFF_PIN) begin
      nxt_st.pin.dir = pin_new[gepc_pkg::GEPC_PIN_DIR_LSB +: 8];
      nxt_st.pin.out = pin_new[gepc_pkg::GEPC_PIN_OUT_LSB +: 8];
    end

    // Cycle end from the engine; a read result is kept for software.
    if (st_ff.ee.req && ee_done_i) begin
      nxt_st.ee.req = 1'b0;
      if (st_ff.ee.cmd == gepc_pkg::GEPC_CMD_READ) begin
        nxt_st.ee_rdata = ee_rdata_i;
      end
    end

    // Field writes are frozen while a cycle runs so the engine sees stable
    // operands.
    if (wb_commit && wb_adr_i == gepc_pkg::GEPC_OFF_EEP && !st_ff.ee.req) begin
      nxt_st.ee.preload = eep_new[gepc_pkg::GEPC_EE_PRE_BIT];
      nxt_st.ee.cmd = gepc_pkg::gepc_cmd_e'(cmd_new);
      nxt_st.ee.addr = eep_new[gepc_pkg::GEPC_EE_ADR_LSB +: 11];
      nxt_st.ee.wdata = eep_new[gepc_pkg::GEPC_EE_WD_LSB +: 16];
      if (start_new) begin
        if (cmd_new == gepc_pkg::GEPC_CMD_WRITE ||
            cmd_new == gepc_pkg::GEPC_CMD_READ) begin
          launch = 1'b1;
        end else begin
          nxt_st.ee_rej = 1'b1;
        end
      end
    end

    // A good launch raises the request and clears an old refusal flag; done
    // cannot meet it, as a launch is only taken while idle.
    if (launch) begin
      nxt_st.ee.req = 1'b1;
      nxt_st.ee_rej = 1'b0;
    end

    // Auto-load may replace the role-based error reporting default.
    if (rbe_load_i) begin
      nxt_st.rbe = rbe_value_i;
    end

    // Captured slot power fields follow each received limit message.
    if (spl_msg_i) begin
      nxt_st.spv = spl_value_i;
      nxt_st.sps = spl_scale_i;
    end
  end

  // ---------------------------------------------------------------------
  // State register.
  // ---------------------------------------------------------------------

  // Synchronous reset; every field takes a constant.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff.sync1 <= gepc_pkg::GEPC_BYTE_ZERO;
      st_ff.sync2 <= gepc_pkg::GEPC_BYTE_ZERO;
      st_ff.pin.dir <= gepc_pkg::GEPC_BYTE_ZERO;
      st_ff.pin.out <= gepc_pkg::GEPC_BYTE_ZERO;
      st_ff.ee.req <= 1'b0;
      st_ff.ee.cmd <= gepc_pkg::GEPC_CMD_RSV0;
      st_ff.ee.addr <= 11'h000;
      st_ff.ee.wdata <= 16'h0000;
      st_ff.ee.preload <= 1'b0;
      st_ff.ee_rej <= 1'b0;
      st_ff.ee_rdata <= 16'h0000;
      st_ff.rbe <= gepc_pkg::GEPC_DEV_RBE_RST;
      st_ff.spv <= gepc_pkg::GEPC_SPV_RST;
      st_ff.sps <= gepc_pkg::GEPC_SPS_RST;
      st_ff.ack <= 1'b0;
      st_ff.rdat <= gepc_pkg::GEPC_WORD_ZERO;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs, all straight from flip-flops.
  // ---------------------------------------------------------------------

  // Output level is gated by the enable at the pin pad, not here, so a
  // preset level appears the moment the direction flips.
  assign wb_ack_o = st_ff.ack;
  assign wb_dat_o = st_ff.rdat;
  assign pin_out_o = st_ff.pin.out;
  assign pin_oe_o = st_ff.pin.dir;
  assign ee_req_o = st_ff.ee.req;
  assign ee_cmd_o = st_ff.ee.cmd;
  assign ee_addr_o = st_ff.ee.addr;
  assign ee_wdata_o = st_ff.ee.wdata;
  assign ee_preload_o = st_ff.ee.preload;

endmodule : gepc_regs

`default_nettype wire

// *** core/gepc_pkg.sv ***
// Constants, field layouts and carrier types for the pin, EEPROM access and
// capability register slice.
// Assumes a single 25 MHz clock domain and a 32-bit classic Wishbone slave.
package gepc_pkg;

  // ---------------------------------------------------------------------
  // Register byte offsets.
  // ---------------------------------------------------------------------
  localparam logic [7:0] GEPC_OFF_PIN = 8'hD8;
  localparam logic [7:0] GEPC_OFF_EEP = 8'hDC;
  localparam logic [7:0] GEPC_OFF_CAP = 8'hE0;
  localparam logic [7:0] GEPC_OFF_DEV = 8'hE4;
  localparam logic [7:0] GEPC_OFF_EST = 8'hF0;

  // ---------------------------------------------------------------------
  // Field positions.
  // ---------------------------------------------------------------------
  localparam int GEPC_PIN_IN_LSB = 0;
  localparam int GEPC_PIN_DIR_LSB = 8;
  localparam int GEPC_PIN_OUT_LSB = 16;
  localparam int GEPC_EE_START_BIT = 0;
  localparam int GEPC_EE_PRE_BIT = 2;
  localparam int GEPC_EE_CMD_LSB = 3;
  localparam int GEPC_EE_ADR_LSB = 5;
  localparam int GEPC_EE_WD_LSB = 16;
  localparam int GEPC_EST_BUSY_BIT = 0;
  localparam int GEPC_EST_REJ_BIT = 1;
  localparam int GEPC_EST_RD_LSB = 16;
  localparam int GEPC_CAP_ID_LSB = 0;
  localparam int GEPC_CAP_NXT_LSB = 8;
  localparam int GEPC_CAP_VER_LSB = 16;
  localparam int GEPC_CAP_TYPE_LSB = 20;
  localparam int GEPC_CAP_SLOT_BIT = 24;
  localparam int GEPC_CAP_MSG_LSB = 25;
  localparam int GEPC_DEV_MPS_LSB = 0;
  localparam int GEPC_DEV_PH_LSB = 3;
  localparam int GEPC_DEV_ETAG_BIT = 5;
  localparam int GEPC_DEV_L0S_LSB = 6;
  localparam int GEPC_DEV_L1_LSB = 9;
  localparam int GEPC_DEV_ABP_BIT = 12;
  localparam int GEPC_DEV_AIP_BIT = 13;
  localparam int GEPC_DEV_PIP_BIT = 14;
  localparam int GEPC_DEV_RBE_BIT = 15;
  localparam int GEPC_DEV_SPV_LSB = 18;
  localparam int GEPC_DEV_SPS_LSB = 26;

  // ---------------------------------------------------------------------
  // Fixed field values and reset values.
  // ---------------------------------------------------------------------
  localparam logic [7:0] GEPC_CAP_ID = 8'h10;
  localparam logic [7:0] GEPC_CAP_NEXT = 8'h00;
  localparam logic [3:0] GEPC_CAP_VER = 4'h1;
  localparam logic [3:0] GEPC_CAP_TYPE = 4'h1;
  localparam logic [0:0] GEPC_CAP_SLOT = 1'h0;
  localparam logic [4:0] GEPC_CAP_MSG = 5'h00;
  localparam logic [2:0] GEPC_DEV_MPS = 3'h0;
  localparam logic [1:0] GEPC_DEV_PHANTOM = 2'h0;
  localparam logic [0:0] GEPC_DEV_UNIMPL = 1'h0;
  localparam logic [2:0] GEPC_DEV_LAT_RST = 3'h0;
  localparam logic [0:0] GEPC_DEV_RBE_RST = 1'h1;
  localparam logic [7:0] GEPC_SPV_RST = 8'h00;
  localparam logic [1:0] GEPC_SPS_RST = 2'h0;
  localparam logic [7:0] GEPC_BYTE_ZERO = 8'h00;
  localparam logic [31:0] GEPC_WORD_ZERO = 32'h00000000;

  // ---------------------------------------------------------------------
  // EEPROM command codes.
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    GEPC_CMD_RSV0 = 2'b00,
    GEPC_CMD_WRITE = 2'b01,
    GEPC_CMD_READ = 2'b10,
    GEPC_CMD_RSV3 = 2'b11
  } gepc_cmd_e;

  // ---------------------------------------------------------------------
  // Carrier types.
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic req;
    gepc_cmd_e cmd;
    logic [10:0] addr;
    logic [15:0] wdata;
    logic preload;
  } gepc_eereq_s;

  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] out;
  } gepc_pin_s;

endpackage : gepc_pkg

// *** sim/gepc_regs_asserts.sv ***
// Checker for the register slice: bus pulse, pin, capability and EEPROM
// launch behaviour.
// Assumes it is bound to gepc_regs and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module gepc_regs_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [7:0] pin_in_i,
  input wire logic [7:0] pin_oe_o,
  input wire logic ee_req_o,
  input wire logic [1:0] ee_cmd_o,
  input wire logic [10:0] ee_addr_o,
  input wire logic [15:0] ee_wdata_o,
  input wire logic ee_done_i,
  input wire logic rbe_load_i,
  input wire logic rbe_value_i,
  input wire logic spl_msg_i,
  input wire logic [7:0] spl_value_i,
  input wire logic [1:0] spl_scale_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [12:0] dev_ff;
  logic [12:0] nxt_dev;
  logic [31:0] dq_ff;
  wire rd_w = wb_ack_o && !wb_we_i;
  wire wr_w = wb_ack_o && wb_we_i;
  wire go_w = wr_w && wb_adr_i == 8'hDC && wb_sel_i == 4'hF && wb_dat_i[0]
    && !ee_req_o;
  // Expected device word from the shadow; read data is one cycle older.
  wire [31:0] dev_w = {4'h0, dev_ff[12:3], 2'b00, dev_ff[0], 15'h0000};
  // ------
  // Shadow of the loaded capability fields, so reads can be judged.
  // ------
  always_comb begin
    nxt_dev = dev_ff;
    if (rbe_load_i) nxt_dev[0] = rbe_value_i;
    if (spl_msg_i) nxt_dev[12:3] = {spl_scale_i, spl_value_i};
    if (rst_i) nxt_dev = 13'h0001;
  end
  // Written data is kept one cycle, as $past is given signals only.
  always_ff @(posedge clk_i) begin
    dev_ff <= nxt_dev;
    dq_ff <= wb_dat_i;
  end
  a_ack_pulse:
  assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  a_ack_answer:
  assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered");
  a_dir_write:
  assert property (wr_w && wb_adr_i == 8'hD8 && wb_sel_i[1]
    |=> pin_oe_o == dq_ff[15:8]) else $error("direction not written");
  a_pin_sample:
  assert property (rd_w && wb_adr_i == 8'hD8 && pin_in_i == $past(pin_in_i)
    && pin_in_i == $past(pin_in_i, 2) && pin_in_i == $past(pin_in_i, 3)
    |-> wb_dat_o[7:0] == pin_in_i && wb_dat_o[31:24] == 8'h00)
    else $error("pin word read wrong");
  a_cap_word:
  assert property (rd_w && wb_adr_i == 8'hE0 |-> wb_dat_o == 32'h00110010)
    else $error("capability header wrong");
  a_dev_word:
  assert property (rd_w && wb_adr_i == 8'hE4 |-> wb_dat_o == $past(dev_w))
    else $error("device capability word wrong");
  a_ee_launch:
  assert property (go_w && wb_dat_i[4] != wb_dat_i[3] |=> ee_req_o
    && ee_cmd_o == dq_ff[4:3] && ee_addr_o == dq_ff[15:5]
    && ee_wdata_o == dq_ff[31:16]) else $error("eeprom launch wrong");
  a_ee_refuse:
  assert property (go_w && wb_dat_i[4] == wb_dat_i[3] |=> !ee_req_o)
    else $error("reserved command launched");
  a_ee_hold:
  assert property (ee_req_o && !ee_done_i |=> ee_req_o
    && $stable(ee_addr_o) && $stable(ee_cmd_o)) else $error("request moved");
  a_ee_end:
  assert property (ee_req_o && ee_done_i |=> !ee_req_o)
    else $error("request not ended");
  c_launch: cover property (go_w);
  c_rbe_low: cover property (rd_w && wb_adr_i == 8'hE4 && !dev_ff[0]);
  c_ee_done: cover property (ee_req_o && ee_done_i);
endmodule : gepc_regs_asserts
bind gepc_regs gepc_regs_asserts chk_u (.*);
`default_nettype wire

// *** sim/gepc_ee_model.sv ***
// Behavioural EEPROM engine answering one request after a set latency.
// Assumes the request holds until the done pulse, on the same clock.
`timescale 1ns/1ns
`default_nettype none
module gepc_ee_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic [1:0] cmd_i,
  input wire logic [10:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [3:0] lat_i,
  output logic done_o,
  output logic [15:0] rdata_o
);
  logic [15:0] mem_ff [2048];
  logic [3:0] cnt_ff;
  // Read data toggles outside a done pulse, so stale data is never trusted.
  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (rst_i) begin
      cnt_ff <= 4'h0;
      rdata_o <= 16'h5A5A;
    end else if (req_i && !done_o) begin
      cnt_ff <= cnt_ff + 4'h1;
      if (cnt_ff >= lat_i) begin
        done_o <= 1'b1;
        cnt_ff <= 4'h0;
        if (cmd_i == 2'b01) mem_ff[addr_i] <= wdata_i;
        else rdata_o <= mem_ff[addr_i];
      end
    end
  end
endmodule : gepc_ee_model
`default_nettype wire

// *** sim/gepc_regs_tb.sv ***
// Self-checking bench: Wishbone master, pin pads, EEPROM engine model.
// Assumes gepc_regs and gepc_ee_model are compiled before it.
`timescale 1ns/1ns
`default_nettype none
module gepc_regs_tb;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ee_req_o;
  logic ee_preload_o, ee_done_i, rbe_load_i, rbe_value_i, spl_msg_i;
  logic [7:0] wb_adr_i, pin_out_o, pin_oe_o, spl_value_i, ext_pin;
  logic [3:0] wb_sel_i, lat, s;
  logic [31:0] wb_dat_i, wb_dat_o, pin_w, v;
  logic [1:0] ee_cmd_o, spl_scale_i;
  logic [1:0] cmd_t [4] = '{2'b01, 2'b10, 2'b00, 2'b11};
  logic [10:0] ee_addr_o;
  logic [15:0] ee_wdata_o, ee_rdata_i;
  logic [31:0] exp_q [$];
  logic [31:0] msk_q [$];
  int errors = 0;
  int total_checks = 0;
  // Pad level: the design drives where enabled, the outside elsewhere.
  wire logic [7:0] pin_in_i = (pin_oe_o & pin_out_o) | (~pin_oe_o & ext_pin);
  gepc_regs dut_u (.*);
  gepc_ee_model ee_u (.clk_i(clk_i), .rst_i(rst_i), .req_i(ee_req_o),
    .cmd_i(ee_cmd_o), .addr_i(ee_addr_o), .wdata_i(ee_wdata_o), .lat_i(lat),
    .done_o(ee_done_i), .rdata_o(ee_rdata_i));
  // ------
  // Clock, watchdog and shared tasks.
  // ------
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    errors++;
    complete_run();
  end
  task automatic complete_run();
    if (errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, exp, msk);
    total_checks++;
    if ((got & msk) !== (exp & msk)) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // The request holds until ack is seen high, then drops for a cycle.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [3:0] sl, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= sl;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(1'b0, a, 4'hF, 32'h0);
  endtask : rd
  task automatic wait_idle();
    @(posedge clk_i);
    while (ee_req_o !== 1'b0) @(posedge clk_i);
  endtask : wait_idle
  // Read data is judged at the edge where the master takes it.
  always @(posedge clk_i)
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
      chk(wb_dat_o, exp_q.pop_front(), msk_q.pop_front());
  // ------
  // Main sequence.
  // ------
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, rbe_load_i, rbe_value_i, spl_msg_i} = '0;
    {wb_adr_i, wb_sel_i, wb_dat_i, spl_value_i, spl_scale_i} = '0;
    ext_pin = 8'h00;
    lat = 4'h0;
    rst_i = 1'b1;
    v = $urandom(32'h45DF662E);
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    // Fixed words, before and after writes of all ones.
    for (int k = 0; k < 2; k++) begin
      rd(8'hD8, 32'h0, ALL);
      rd(8'hDC, 32'h0, ALL);
      rd(8'hE0, 32'h00110010, ALL);
      rd(8'hE4, 32'h00008000, ALL);
      rd(8'h40, 32'h0, ALL);
      bus(1'b1, 8'hE0, 4'hF, ALL);
      bus(1'b1, 8'hE4, 4'hF, ALL);
      bus(1'b1, 8'h40, 4'hF, ALL);
    end
    // Pin word with random byte enables and pad levels.
    pin_w = 32'h0;
    for (int k = 0; k < 8; k++) begin
      v = $urandom;
      s = 4'($urandom);
      bus(1'b1, 8'hD8, s, v);
      for (int b = 1; b < 3; b++) if (s[b]) pin_w[8*b +: 8] = v[8*b +: 8];
      ext_pin <= v[31:24];
      repeat (3) @(posedge clk_i);
      chk(pin_oe_o, pin_w[15:8], 32'hFF);
      chk(pin_out_o, pin_w[23:16], 32'hFF);
      rd(8'hD8, {8'h00, pin_w[23:8], (pin_w[15:8] & pin_w[23:16])
        | (~pin_w[15:8] & v[31:24])}, ALL);
    end
    // Write, read back, then both reserved commands.
    v = $urandom;
    for (int k = 0; k < 4; k++) begin
      lat <= (k == 0) ? 4'h6 : 4'($urandom % 4);
      bus(1'b1, 8'hDC, 4'hF, {v[31:5], cmd_t[k], 3'b101});
      if (k == 0) bus(1'b1, 8'hDC, 4'hF, ~v);
      wait_idle();
      chk(ee_preload_o, 32'h1, 32'h1);
      rd(8'hDC, {v[31:5], cmd_t[k], 3'b100}, ALL);
      rd(8'hF0, {v[31:16], 14'h0, cmd_t[k][0] == cmd_t[k][1], 1'b0},
        (k == 0) ? 32'h0000FFFF : ALL);
    end
    // Loaded capability fields, then a reset in mid-run.
    @(posedge clk_i);
    rbe_load_i <= 1'b1;
    spl_msg_i <= 1'b1;
    {spl_scale_i, spl_value_i} <= v[9:0];
    @(posedge clk_i);
    rbe_load_i <= 1'b0;
    spl_msg_i <= 1'b0;
    {spl_scale_i, spl_value_i} <= ~v[9:0];
    rd(8'hE4, {4'h0, v[9:0], 18'h0}, ALL);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'hE4, 32'h00008000, ALL);
    // Let the last read be judged, and count any note left unanswered.
    @(posedge clk_i);
    if (exp_q.size() != 0) errors++;
    complete_run();
  end
endmodule : gepc_regs_tb
`default_nettype wire
